// [gpio_peripheral_pin_mux.sv]
// module: per-pin gpio / peripheral selection for ports b to e and timer
`timescale 1ns/1ps
`default_nettype none
module gpio_peripheral_pin_mux #(
    parameter int PB_W = 16,
    parameter int PC_W = 12,
    parameter int PD_W = 2,
    parameter int PE_OWN_W = 6,
    parameter int PE_SHR_W = 4
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic soft_rst_i,
    // host parallel port mode and peripheral side
    input wire pin_mux_pkg::host_mode_t host_mode_i,
    input wire pin_mux_pkg::pin_drive_t host_periph_i,
    output logic [PB_W-1:0] host_in_o,
    // port b gpio settings
    input wire logic [PB_W-1:0] pb_dir_i,
    input wire logic [PB_W-1:0] pb_data_i,
    output logic [PB_W-1:0] pb_in_o,
    // port b pins
    input wire logic [PB_W-1:0] pb_pin_i,
    output logic [PB_W-1:0] pb_pin_o,
    output logic [PB_W-1:0] pb_pin_oe_o,
    // port c: first serial audio port
    input wire logic [PC_W-1:0] pc_ctrl_i,
    input wire logic [PC_W-1:0] pc_dir_i,
    input wire logic [PC_W-1:0] pc_data_i,
    input wire logic [PC_W-1:0] sap1_out_i,
    input wire logic [PC_W-1:0] sap1_oe_i,
    output logic [PC_W-1:0] sap1_in_o,
    output logic [PC_W-1:0] pc_in_o,
    input wire logic [PC_W-1:0] pc_pin_i,
    output logic [PC_W-1:0] pc_pin_o,
    output logic [PC_W-1:0] pc_pin_oe_o,
    // port d: audio transmitter
    input wire logic [PD_W-1:0] pd_ctrl_i,
    input wire logic [PD_W-1:0] pd_dir_i,
    input wire logic [PD_W-1:0] pd_data_i,
    input wire logic [PD_W-1:0] atx_out_i,
    input wire logic [PD_W-1:0] atx_oe_i,
    output logic [PD_W-1:0] atx_in_o,
    output logic [PD_W-1:0] pd_in_o,
    input wire logic [PD_W-1:0] pd_pin_i,
    output logic [PD_W-1:0] pd_pin_o,
    output logic [PD_W-1:0] pd_pin_oe_o,
    // port e: second serial audio port
    input wire logic [PE_OWN_W+PE_SHR_W-1:0] pe_ctrl_i,
    input wire logic [PE_OWN_W+PE_SHR_W-1:0] pe_dir_i,
    input wire logic [PE_OWN_W+PE_SHR_W-1:0] pe_data_i,
    input wire logic [PE_OWN_W+PE_SHR_W-1:0] sap2_out_i,
    input wire logic [PE_OWN_W+PE_SHR_W-1:0] sap2_oe_i,
    output logic [PE_OWN_W+PE_SHR_W-1:0] sap2_in_o,
    output logic [PE_OWN_W+PE_SHR_W-1:0] pe_in_o,
    input wire logic [PE_OWN_W-1:0] pe_pin_i,
    output logic [PE_OWN_W-1:0] pe_pin_o,
    output logic [PE_OWN_W-1:0] pe_pin_oe_o,
    // timer pin
    input wire logic timer_use_i,
    input wire logic timer_out_i,
    input wire logic timer_oe_i,
    input wire logic timer_gpio_dir_i,
    input wire logic timer_gpio_data_i,
    output logic timer_in_o,
    output logic timer_gpio_in_o,
    input wire logic timer_pin_i,
    output logic timer_pin_o,
    output logic timer_pin_oe_o,
    // role view
    output logic [36:0] periph_role_o
);
    localparam int PE_W = PE_OWN_W + PE_SHR_W;

    // ----------------------------------------
    // host port mode register
    // ----------------------------------------
    // mode is captured so that a soft reset forces gpio from the next clock edge
    logic host_en_ff;
    logic [PB_W-1:0] host_keep_ff;
    logic [PB_W-1:0] host_claim;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_en_ff <= 1'b0;
            host_keep_ff <= '0;
        end else if (soft_rst_i) begin
            host_en_ff <= 1'b0;
            host_keep_ff <= '0;
        end else begin
            host_en_ff <= host_mode_i.enable;
            host_keep_ff <= host_mode_i.gpio_keep[PB_W-1:0] & pin_mux_pkg::HOST_GPIO_ABLE[PB_W-1:0];
        end
    end

    // pins map one to one onto port b bits; modes only rename them
    assign host_claim = host_en_ff ? ~host_keep_ff : '0;

    // ----------------------------------------
    // generic per-pin select
    // ----------------------------------------
    function automatic logic sel(input logic claim, input logic p, input logic g);
        sel = claim ? p : g;
    endfunction

    genvar i;
    generate
        for (i = 0; i < PB_W; i++) begin : g_pb
            assign pb_pin_o[i] = sel(host_claim[i], host_periph_i.out[i], pb_data_i[i]);
            assign pb_pin_oe_o[i] = sel(host_claim[i], host_periph_i.oe[i], pb_dir_i[i]);
            assign host_in_o[i] = host_claim[i] & pb_pin_i[i];
            assign pb_in_o[i] = ~host_claim[i] & pb_pin_i[i];
        end
        for (i = 0; i < PC_W; i++) begin : g_pc
            assign pc_pin_o[i] = sel(pc_ctrl_i[i], sap1_out_i[i], pc_data_i[i]);
            assign pc_pin_oe_o[i] = sel(pc_ctrl_i[i], sap1_oe_i[i], pc_dir_i[i]);
            assign sap1_in_o[i] = pc_ctrl_i[i] & pc_pin_i[i];
            assign pc_in_o[i] = ~pc_ctrl_i[i] & pc_pin_i[i];
        end
        for (i = 0; i < PD_W; i++) begin : g_pd
            assign pd_pin_o[i] = sel(pd_ctrl_i[i], atx_out_i[i], pd_data_i[i]);
            assign pd_pin_oe_o[i] = sel(pd_ctrl_i[i], atx_oe_i[i], pd_dir_i[i]);
            assign atx_in_o[i] = pd_ctrl_i[i] & pd_pin_i[i];
            assign pd_in_o[i] = ~pd_ctrl_i[i] & pd_pin_i[i];
        end
        for (i = 0; i < PE_OWN_W; i++) begin : g_pe
            assign pe_pin_o[i] = sel(pe_ctrl_i[i], sap2_out_i[i], pe_data_i[i]);
            assign pe_pin_oe_o[i] = sel(pe_ctrl_i[i], sap2_oe_i[i], pe_dir_i[i]);
            assign sap2_in_o[i] = pe_ctrl_i[i] & pe_pin_i[i];
            assign pe_in_o[i] = ~pe_ctrl_i[i] & pe_pin_i[i];
        end
    endgenerate

    // ----------------------------------------
    // port e signals on port c pins
    // ----------------------------------------
    // shared pins are the top port c pins; port c keeps priority
    // limitation: drive of these pins is left to port c's output path
    logic [PE_SHR_W-1:0] shr_pin;
    logic [PE_SHR_W-1:0] shr_free;
    assign shr_pin = pc_pin_i[PC_W-1 -: PE_SHR_W];
    generate
        for (i = 0; i < PE_SHR_W; i++) begin : g_shr
            // pin given to port c as a gpio output (pc_dir_i set) counts as claimed by port c for pe_in_o, not for sap2_in_o
            assign shr_free[i] = ~pc_ctrl_i[PC_W-PE_SHR_W+i] & ~pc_dir_i[PC_W-PE_SHR_W+i]
                & ~pe_ctrl_i[PE_OWN_W+i];
            assign sap2_in_o[PE_OWN_W+i] = pe_ctrl_i[PE_OWN_W+i] & ~pc_ctrl_i[PC_W-PE_SHR_W+i]
                & shr_pin[i];
            assign pe_in_o[PE_OWN_W+i] = shr_free[i] & shr_pin[i];
        end
    endgenerate

    // ----------------------------------------
    // timer pin
    // ----------------------------------------
    assign timer_pin_o = sel(timer_use_i, timer_out_i, timer_gpio_data_i);
    assign timer_pin_oe_o = sel(timer_use_i, timer_oe_i, timer_gpio_dir_i);
    assign timer_in_o = timer_use_i & timer_pin_i;
    assign timer_gpio_in_o = ~timer_use_i & timer_pin_i;

    // 37 role bits: b, c, d, own e, timer
    assign periph_role_o = {timer_use_i, pe_ctrl_i[PE_OWN_W-1:0], pd_ctrl_i, pc_ctrl_i,
        host_claim};
endmodule
`default_nettype wire

// [pin_mux_pkg.sv]
// package: pin mux constants and carrier types
package pin_mux_pkg;
    // ----------------------------------------
    // pin counts
    // ----------------------------------------
    localparam int PORT_B_W = 16;
    localparam int PORT_C_W = 12;
    localparam int PORT_D_W = 2;
    localparam int PORT_E_W = 10;
    localparam int PORT_E_OWN_W = 6;
    localparam int PORT_E_SHR_W = 4;
    localparam int TOTAL_PINS = 37;
    localparam int HOST_REG_COUNT = 8;
    localparam int HOST_ACCESS_W = 8;
    // ----------------------------------------
    // port b bit positions of host pins
    // ----------------------------------------
    localparam int PB_ADDR_STROBE = 8;
    localparam int PB_ADDR_LINE8 = 9;
    localparam int PB_ADDR_LINE9 = 10;
    localparam int PB_READ_WRITE = 11;
    localparam int PB_DATA_STROBE = 12;
    localparam int PB_CHIP_SELECT = 13;
    localparam int PB_REQUEST = 14;
    localparam int PB_ACKNOWLEDGE = 15;
    // pins that may stay gpio while the host port is on
    localparam logic [15:0] HOST_GPIO_ABLE = 16'he600;
    localparam logic [15:0] RST_ZERO_16 = 16'h0000;

    // one group of pin signals, sized to the widest port
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } pin_drive_t;

    typedef struct packed {
        logic enable;
        logic muxed_bus;
        logic dual_strobe;
        logic no_vector;
        logic [15:0] gpio_keep;
    } host_mode_t;
endpackage

// [gpio_peripheral_pin_mux_sva.sv]
// checker: pin mux port relations
`timescale 1ns/1ps
`default_nettype none
module pin_mux_chk (
    // clock, reset, host side
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic soft_rst_i,
    input wire pin_mux_pkg::host_mode_t host_mode_i,
    input wire pin_mux_pkg::pin_drive_t host_periph_i,
    input wire logic [15:0] pb_dir_i,
    input wire logic [15:0] pb_pin_oe_o,
    // peripheral ports
    input wire logic [11:0] pc_ctrl_i,
    input wire logic [11:0] pc_dir_i,
    input wire logic [11:0] sap1_oe_i,
    input wire logic [11:0] pc_pin_oe_o,
    input wire logic [9:0] pe_ctrl_i,
    input wire logic [9:0] pe_dir_i,
    input wire logic [9:0] sap2_oe_i,
    input wire logic [5:0] pe_pin_oe_o,
    input wire logic timer_use_i,
    input wire logic timer_oe_i,
    input wire logic timer_gpio_dir_i,
    input wire logic timer_pin_oe_o,
    input wire logic [36:0] periph_role_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_on;
        host_mode_i.enable && !soft_rst_i;
    endsequence
    sequence s_off;
        !host_mode_i.enable;
    endsequence
    AST_PC_OE: assert property (pc_pin_oe_o == ((pc_ctrl_i & sap1_oe_i) | (~pc_ctrl_i & pc_dir_i)))
        else $error("port c drive wrong");
    AST_PE_OE: assert property (pe_pin_oe_o == ((pe_ctrl_i[5:0] & sap2_oe_i[5:0]) | (~pe_ctrl_i[5:0] & pe_dir_i[5:0])))
        else $error("port e drive wrong");
    AST_TMR_OE: assert property (timer_pin_oe_o == (timer_use_i ? timer_oe_i : timer_gpio_dir_i))
        else $error("timer pin drive wrong");
    AST_HOST_OFF: assert property (s_off |=> pb_pin_oe_o == pb_dir_i)
        else $error("port b not gpio with host off");
    AST_HOST_ON: assert property (s_on |=> (pb_pin_oe_o & 16'h19ff) == (host_periph_i.oe & 16'h19ff))
        else $error("host pin left gpio");
    AST_SOFT_RST: assert property (soft_rst_i |=> pb_pin_oe_o == pb_dir_i)
        else $error("soft reset kept host claim");
    AST_HOST_ROLE: assert property (s_on |=> periph_role_o[15:0] == ~($past(host_mode_i.gpio_keep) & 16'he600))
        else $error("host role wrong");
    AST_ROLE: assert property ({periph_role_o[36:30], periph_role_o[27:16]} == {timer_use_i, pe_ctrl_i[5:0], pc_ctrl_i})
        else $error("role view wrong");
endmodule
`default_nettype wire

// [pin_mux_pins.sv]
// partner: pin levels outside the pin mux
`timescale 1ns/1ps
`default_nettype none
module pin_mux_pins (
    // clock and block drive
    input wire logic mclk_i,
    input wire logic [36:0] out_i,
    input wire logic [36:0] oe_i,
    // level on the pins
    output logic [36:0] lvl_o
);
    logic [36:0] float_ff = 37'h0;
    // no pulls: released pins follow a 37-bit twisted ring, so at most one released pin changes level each cycle
    always_ff @(posedge mclk_i) begin
        float_ff <= {float_ff[35:0], ~float_ff[36]};
    end
    assign lvl_o = (out_i & oe_i) | (float_ff & ~oe_i);
endmodule
`default_nettype wire

// [tb_gpio_peripheral_pin_mux.sv]
// testbench: random pin mux traffic against bench expectations
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_peripheral_pin_mux;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic soft_rst_i = 1'b0;
    pin_mux_pkg::host_mode_t host_mode_i = 20'h00000;
    pin_mux_pkg::pin_drive_t host_periph_i;
    logic [223:0] stim = 224'h0;
    logic [31:0] rs = 32'h00000061;
    logic [15:0] pb_dir_i, pb_data_i, pb_in_o, pb_pin_o, pb_pin_oe_o, host_in_o, hc;
    logic [11:0] pc_ctrl_i, pc_dir_i, pc_data_i, sap1_out_i, sap1_oe_i;
    logic [11:0] sap1_in_o, pc_in_o, pc_pin_o, pc_pin_oe_o;
    logic [1:0] pd_ctrl_i, pd_dir_i, pd_data_i, atx_out_i, atx_oe_i, atx_in_o, pd_in_o;
    logic [1:0] pd_pin_o, pd_pin_oe_o;
    logic [9:0] pe_ctrl_i, pe_dir_i, pe_data_i, sap2_out_i, sap2_oe_i, sap2_in_o, pe_in_o;
    logic [5:0] pe_pin_o, pe_pin_oe_o;
    logic timer_use_i, timer_out_i, timer_oe_i, timer_gpio_dir_i, timer_gpio_data_i;
    logic timer_in_o, timer_gpio_in_o, timer_pin_o, timer_pin_oe_o;
    logic [36:0] periph_role_o, lvl, cl;
    int miscompares = 0;
    int check_count = 0;
    assign {host_periph_i, pb_dir_i, pb_data_i, pc_ctrl_i, pc_dir_i, pc_data_i, sap1_out_i,
        sap1_oe_i, pd_ctrl_i, pd_dir_i, pd_data_i, atx_out_i, atx_oe_i, pe_ctrl_i, pe_dir_i,
        pe_data_i, sap2_out_i, sap2_oe_i, timer_use_i, timer_out_i, timer_oe_i,
        timer_gpio_dir_i, timer_gpio_data_i} = stim[188:0];
    assign cl = {timer_use_i, pe_ctrl_i[5:0], pd_ctrl_i, pc_ctrl_i, hc};
    gpio_peripheral_pin_mux dut (.pb_pin_i(lvl[15:0]), .pc_pin_i(lvl[27:16]),
        .pd_pin_i(lvl[29:28]), .pe_pin_i(lvl[35:30]), .timer_pin_i(lvl[36]), .*);
    pin_mux_pins pins (.mclk_i(mclk_i), .lvl_o(lvl),
        .out_i({timer_pin_o, pe_pin_o, pd_pin_o, pc_pin_o, pb_pin_o}),
        .oe_i({timer_pin_oe_o, pe_pin_oe_o, pd_pin_oe_o, pc_pin_oe_o, pb_pin_oe_o}));
    // expected host claim: only keepable pins may stay gpio
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) hc <= 16'h0000;
        else hc <= (host_mode_i.enable && !soft_rst_i) ?
            ~(host_mode_i.gpio_keep & pin_mux_pkg::HOST_GPIO_ABLE) : 16'h0000;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [36:0] sel(input logic [36:0] c, a, g);
        return (c & a) | (~c & g);
    endfunction
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial forever #25 mclk_i = ~mclk_i;
    initial begin
        for (int i = 0; i < 600; i++) begin
            @(negedge mclk_i);
            chk("oe", {timer_pin_oe_o, pe_pin_oe_o, pd_pin_oe_o, pc_pin_oe_o, pb_pin_oe_o},
                sel(cl, {timer_oe_i, sap2_oe_i[5:0], atx_oe_i, sap1_oe_i, host_periph_i.oe},
                {timer_gpio_dir_i, pe_dir_i[5:0], pd_dir_i, pc_dir_i, pb_dir_i}));
            chk("out", {timer_pin_o, pe_pin_o, pd_pin_o, pc_pin_o, pb_pin_o},
                sel(cl, {timer_out_i, sap2_out_i[5:0], atx_out_i, sap1_out_i, host_periph_i.out},
                {timer_gpio_data_i, pe_data_i[5:0], pd_data_i, pc_data_i, pb_data_i}));
            chk("role", periph_role_o, cl);
            chk("in", {pe_in_o[9:6], sap2_in_o[9:6], host_in_o, pb_in_o},
                {lvl[27:24] & ~pc_ctrl_i[11:8] & ~pc_dir_i[11:8] & ~pe_ctrl_i[9:6],
                lvl[27:24] & pe_ctrl_i[9:6] & ~pc_ctrl_i[11:8], hc & lvl[15:0],
                ~hc & lvl[15:0]});
            chk("in_c", {sap1_in_o, pc_in_o}, {pc_ctrl_i & lvl[27:16], ~pc_ctrl_i & lvl[27:16]});
            chk("in_d", {atx_in_o, pd_in_o}, {pd_ctrl_i & lvl[29:28], ~pd_ctrl_i & lvl[29:28]});
            chk("in_e", {sap2_in_o[5:0], pe_in_o[5:0]}, {pe_ctrl_i[5:0] & lvl[35:30], ~pe_ctrl_i[5:0] & lvl[35:30]});
            chk("in_t", {timer_in_o, timer_gpio_in_o}, {timer_use_i & lvl[36], ~timer_use_i & lvl[36]});
            for (int k = 0; k < 7; k++) begin
                rs = xs(rs);
                stim[k*32 +: 32] = rs;
            end
            rst_b_i = (i >= 10) && !(i >= 300 && i < 304);
            soft_rst_i = (rs[3:1] == 3'h0);
            host_mode_i = (i < 50) ? {1'b1, rs[2:0], (i < 30) ? 16'hffff : 16'h0000} : rs[31:12];
        end
        complete_run();
    end
endmodule
bind gpio_peripheral_pin_mux pin_mux_chk chk (.*);
`default_nettype wire
